// [core/qcmp_edge.sv]
`timescale 1ns/1ps
module qcmp_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic level_async,
  input wire logic rising_sel,
  output logic level_sync,
  output logic edge_event
);
  import qcmp_pkg::*;

  qcmp_edge_state_type state;
  qcmp_edge_state_type next_state;

  // Two-stage synchroniser, a history sample and a warm-up shift
  always_comb begin
    next_state = state;
    if (!enable) begin
      next_state = '0;
    end else begin
      next_state.stage1 = level_async;
      next_state.stage2 = state.stage1;
      next_state.prev = state.stage2;
      next_state.warm = {state.warm[WARM_W-2:0], 1'b1};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level_sync = state.stage2;

  // Edge only once history holds a real sample, so enabling never fakes one
  assign edge_event = state.warm[WARM_W-1] &
    (rising_sel ? (state.stage2 & ~state.prev) : (~state.stage2 & state.prev));

endmodule

// [core/qcmp_pkg.sv]
package qcmp_pkg;

  // Channel count and field widths
  localparam int NUM_CH = 4;
  localparam int POL_W = 3;
  localparam int REG_W = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int WARM_W = 3;

  // Channels from this index upward share the last polarity bit
  localparam int POL_SHARED_CH = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 12'h004;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 12'h008;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET = 12'h00C;

  // Reset values
  localparam logic [REG_W-1:0] CONTROL_RESET = 8'h00;
  localparam logic [NUM_CH-1:0] FLAGS_RESET = 4'h0;
  localparam logic [NUM_CH-1:0] MASK_RESET = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

  // Control register layout: polarity 7:5, interrupt enables 4:1, enable 0
  typedef struct packed {
    logic [POL_W-1:0] edge_polarity_select;
    logic [NUM_CH-1:0] channel_interrupt_enable;
    logic enable;
  } qcmp_control_type;

  // Status register layout: event flags 7:4, live levels 3:0
  typedef struct packed {
    logic [NUM_CH-1:0] channel_event_flag;
    logic [NUM_CH-1:0] comparator_level;
  } qcmp_status_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [STRB_W-1:0] pstrb;
  } qcmp_apb_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } qcmp_apb_rsp_type;

  typedef enum logic [2:0] {
    SEL_STATUS,
    SEL_CONTROL,
    SEL_IRQ_STATUS,
    SEL_IRQ_MASK,
    SEL_NONE
  } qcmp_sel_type;

  // Per-channel sampler state
  typedef struct packed {
    logic stage1;
    logic stage2;
    logic prev;
    logic [WARM_W-1:0] warm;
  } qcmp_edge_state_type;

  // Top-level state
  typedef struct packed {
    qcmp_control_type control;
    logic [NUM_CH-1:0] event_flag;
    logic [NUM_CH-1:0] irq_sticky;
    logic [NUM_CH-1:0] irq_mask;
    qcmp_apb_rsp_type rsp;
    logic irq;
    logic irq_pulse;
  } qcmp_top_state_type;

endpackage

// [core/qcmp_top.sv]
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Four independent comparator channels, irq and polling
// - Comparators run only while global enable set
// - Two interrupt outputs, irq and irq_pulse, each combining all channels
// - Channel interrupts only when its enable set
// - Polarity bits choose rising or falling edges
// - Status read returns live comparator levels
// - Event flag per channel held until read
// - Polarity bit 2 serves channels 2 and 3
// - Status: flags bits 7:4, levels 3:0
// - Control: enable 0, enables 4:1, polarity 7:5
module qcmp_top (
  input wire logic pclk,
  input wire logic presetn,
  input qcmp_pkg::qcmp_apb_req_type apb_req,
  output qcmp_pkg::qcmp_apb_rsp_type apb_rsp,
  input wire logic [qcmp_pkg::NUM_CH-1:0] comparator_level_in,
  output logic comparator_enable,
  output logic irq,
  output logic irq_pulse
);
  import qcmp_pkg::*;

  qcmp_top_state_type state;
  qcmp_top_state_type next_state;

  logic [NUM_CH-1:0] level_sync;
  logic [NUM_CH-1:0] edge_event;
  logic [NUM_CH-1:0] chan_event;
  logic [POL_W-1:0] pol;

  // Address decode, shared by the setup and completion phases
  function automatic qcmp_sel_type decode_sel(input logic [ADDR_W-1:0] addr);
    qcmp_sel_type sel;
    sel = SEL_NONE;
    if (addr == STATUS_OFFSET) begin
      sel = SEL_STATUS;
    end else if (addr == CONTROL_OFFSET) begin
      sel = SEL_CONTROL;
    end else if (addr == IRQ_STATUS_OFFSET) begin
      sel = SEL_IRQ_STATUS;
    end else if (addr == IRQ_MASK_OFFSET) begin
      sel = SEL_IRQ_MASK;
    end
    return sel;
  endfunction

  // Polarity bit that governs a channel
  function automatic int pol_index(input int ch);
    return (ch < POL_SHARED_CH) ? ch : POL_SHARED_CH;
  endfunction

  assign pol = state.control.edge_polarity_select;

  // One sampler per channel; all stay cleared while the block is off
  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
      qcmp_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .enable(state.control.enable),
        .level_async(comparator_level_in[i]),
        .rising_sel(pol[pol_index(i)]),
        .level_sync(level_sync[i]),
        .edge_event(edge_event[i])
      );
      assign chan_event[i] = state.control.enable &
        state.control.channel_interrupt_enable[i] & edge_event[i];
    end
  endgenerate

  always_comb begin
    qcmp_sel_type sel;
    qcmp_status_type stat_word;
    logic setup;
    logic done;
    logic wr_lane0;
    logic [NUM_CH-1:0] flag_clear;
    logic [NUM_CH-1:0] sticky_clear;
    logic [DATA_W-1:0] rdata;
    qcmp_status_type shown;
    sel = decode_sel(apb_req.paddr);
    stat_word = '0;
    setup = 1'b0;
    done = 1'b0;
    wr_lane0 = 1'b0;
    flag_clear = '0;
    sticky_clear = '0;
    rdata = RDATA_RESET;
    shown = '0;
    next_state = state;

    setup = apb_req.psel & ~apb_req.penable;
    done = apb_req.psel & apb_req.penable & state.rsp.pready;
    wr_lane0 = done & apb_req.pwrite & apb_req.pstrb[0];

    // Status word as seen now: live levels, held flags
    stat_word.comparator_level = level_sync;
    stat_word.channel_event_flag = state.event_flag;

    // Read mux, sampled in the setup cycle
    case (sel)
      SEL_STATUS: begin
        rdata = {{(DATA_W-REG_W){1'b0}}, stat_word};
      end
      SEL_CONTROL: begin
        rdata = {{(DATA_W-REG_W){1'b0}}, state.control};
      end
      SEL_IRQ_STATUS: begin
        rdata = {{(DATA_W-NUM_CH){1'b0}}, state.irq_sticky};
      end
      SEL_IRQ_MASK: begin
        rdata = {{(DATA_W-NUM_CH){1'b0}}, state.irq_mask};
      end
      default: begin
        rdata = RDATA_RESET;
      end
    endcase

    // Read of status clears only the flags that were returned
    shown = state.rsp.prdata[REG_W-1:0];
    if (done && !apb_req.pwrite && sel == SEL_STATUS) begin
      flag_clear = shown.channel_event_flag;
    end
    if (wr_lane0 && sel == SEL_IRQ_STATUS) begin
      sticky_clear = apb_req.pwdata[NUM_CH-1:0];
    end

    // New events win over a clear in the same cycle
    next_state.event_flag = (state.event_flag & ~flag_clear) | chan_event;
    next_state.irq_sticky = (state.irq_sticky & ~sticky_clear) | chan_event;

    if (wr_lane0 && sel == SEL_CONTROL) begin
      next_state.control = apb_req.pwdata[REG_W-1:0];
    end
    if (wr_lane0 && sel == SEL_IRQ_MASK) begin
      next_state.irq_mask = apb_req.pwdata[NUM_CH-1:0];
    end

    // Zero-wait answer: ready in the first access cycle
    if (setup) begin
      next_state.rsp.pready = 1'b1;
      next_state.rsp.pslverr = (sel == SEL_NONE);
      next_state.rsp.prdata = apb_req.pwrite ? RDATA_RESET : rdata;
    end else if (done) begin
      next_state.rsp.pready = 1'b0;
      next_state.rsp.pslverr = 1'b0;
      next_state.rsp.prdata = RDATA_RESET;
    end

    next_state.irq_pulse = |chan_event;
    next_state.irq = |(next_state.irq_sticky & next_state.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.control <= CONTROL_RESET;
      state.event_flag <= FLAGS_RESET;
      state.irq_sticky <= FLAGS_RESET;
      state.irq_mask <= MASK_RESET;
      state.rsp <= '0;
      state.irq <= 1'b0;
      state.irq_pulse <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign apb_rsp = state.rsp;
  assign comparator_enable = state.control.enable;
  assign irq = state.irq;
  assign irq_pulse = state.irq_pulse;

endmodule

// [verif/qcmp_asserts.sv]
`timescale 1ns/1ps
module qcmp_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input qcmp_pkg::qcmp_apb_req_type apb_req,
  input qcmp_pkg::qcmp_apb_rsp_type apb_rsp,
  input wire logic [qcmp_pkg::NUM_CH-1:0] comparator_level_in,
  input wire logic comparator_enable,
  input wire logic irq,
  input wire logic irq_pulse
);
  import qcmp_pkg::*;
  logic setup;
  logic done;
  assign setup = apb_req.psel && !apb_req.penable;
  assign done = apb_req.psel && apb_req.penable && apb_rsp.pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY: assert property (setup |=> apb_rsp.pready) else $error("no ready");
  AST_READY_ONE: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("long ready");
  AST_IDLE: assert property (!apb_rsp.pready |-> apb_rsp.prdata == '0) else $error("idle data");
  AST_STAT_HI: assert property (done && !apb_req.pwrite && apb_req.paddr == STATUS_OFFSET
    |-> apb_rsp.prdata[31:8] == '0) else $error("status upper bits");
  AST_UNMAP: assert property (setup && apb_req.paddr > IRQ_MASK_OFFSET
    |=> apb_rsp.pslverr && apb_rsp.prdata == '0) else $error("unmapped");
  AST_EN: assert property (done && apb_req.pwrite && apb_req.paddr == CONTROL_OFFSET
    && apb_req.pstrb[0] |-> ##[1:2] comparator_enable == $past(apb_req.pwdata[0]))
    else $error("enable bit");
  AST_OFF: assert property (!comparator_enable [*3] |-> !irq_pulse) else $error("event off");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(done) || $past(done, 2))
    else $error("irq fell");
  AST_IRQ_RISE: assert property ($rose(irq) |-> irq_pulse || $past(done))
    else $error("irq rose");
endmodule
bind qcmp_top qcmp_asserts u_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .comparator_level_in(comparator_level_in),
  .comparator_enable(comparator_enable), .irq(irq), .irq_pulse(irq_pulse));

// [verif/qcmp_comp_model.sv]
`timescale 1ns/1ps
module qcmp_comp_model (
  input wire logic pclk,
  input wire logic enable,
  input wire logic [qcmp_pkg::NUM_CH-1:0] target,
  output logic [qcmp_pkg::NUM_CH-1:0] level
);
  import qcmp_pkg::*;
  initial level = '0;
  // Four comparators; a disabled comparator outputs low
  always @(posedge pclk) begin
    level <= enable ? target : '0;
  end
endmodule

// [verif/qcmp_top_test.sv]
`timescale 1ns/1ps
module qcmp_top_test;
  import qcmp_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  qcmp_apb_req_type req = '0;
  qcmp_apb_rsp_type rsp;
  logic [NUM_CH-1:0] target = '0;
  logic [3:0] strb = 4'hF;
  logic [NUM_CH-1:0] lvl;
  logic cen;
  logic irq;
  int n_mismatch = 0;
  int n_tests = 0;
  always #10 pclk = ~pclk;
  qcmp_top u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .comparator_level_in(lvl), .comparator_enable(cen), .irq(irq), .irq_pulse());
  qcmp_comp_model u_comp (.pclk(pclk), .enable(cen), .target(target), .level(lvl));
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: strb};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      chk("pready", 32'h0000_0000, 32'h0000_0001);
      close_out();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    xfer(1'b0, a, 32'h0000_0000, q, e);
    chk(nm, q, x);
    chk("pslverr", {31'h0, e}, {31'h0, xe});
  endtask
  task automatic drive(input logic [3:0] v);
    @(posedge pclk);
    target <= v;
    repeat (6) @(posedge pclk);
  endtask
  task automatic t_reset();
    rd("control", CONTROL_OFFSET, 32'h0000_0000, 1'b0);
    rd("status", STATUS_OFFSET, 32'h0000_0000, 1'b0);
    rd("unmapped", 12'h010, 32'h0000_0000, 1'b1);
  endtask
  task automatic t_edges();
    wr(CONTROL_OFFSET, 32'h0000_00A1);
    wr(IRQ_MASK_OFFSET, 32'h0000_000F);
    drive(4'h0);
    wr(CONTROL_OFFSET, 32'h0000_00BF);
    rd("control", CONTROL_OFFSET, 32'h0000_00BF, 1'b0);
    drive(4'hF);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    rd("status", STATUS_OFFSET, 32'h0000_00DF, 1'b0);
    rd("status", STATUS_OFFSET, 32'h0000_000F, 1'b0);
    drive(4'h0);
    rd("status", STATUS_OFFSET, 32'h0000_0020, 1'b0);
    rd("irq_status", IRQ_STATUS_OFFSET, 32'h0000_000F, 1'b0);
    wr(IRQ_STATUS_OFFSET, 32'h0000_000F);
    drive(4'h0);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
  endtask
  task automatic t_mask();
    wr(IRQ_MASK_OFFSET, 32'h0000_0000);
    drive(4'h1);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    rd("status", STATUS_OFFSET, 32'h0000_0011, 1'b0);
    wr(IRQ_MASK_OFFSET, 32'h0000_0001);
    drive(4'h1);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    wr(IRQ_STATUS_OFFSET, 32'h0000_0001);
  endtask
  task automatic t_ie_off();
    wr(CONTROL_OFFSET, 32'h0000_00A1);
    drive(4'h4);
    rd("status", STATUS_OFFSET, 32'h0000_0004, 1'b0);
    wr(CONTROL_OFFSET, 32'h0000_0000);
    drive(4'hF);
    chk("enable", {31'h0, cen}, 32'h0000_0000);
    rd("status", STATUS_OFFSET, 32'h0000_0000, 1'b0);
  endtask
  task automatic t_pol();
    wr(CONTROL_OFFSET, 32'h0000_0041);
    drive(4'hF);
    wr(CONTROL_OFFSET, 32'h0000_005F);
    strb = 4'hE;
    wr(CONTROL_OFFSET, 32'h0000_0000);
    strb = 4'hF;
    wr(STATUS_OFFSET, 32'h0000_00FF);
    rd("control", CONTROL_OFFSET, 32'h0000_005F, 1'b0);
    rd("status", STATUS_OFFSET, 32'h0000_000F, 1'b0);
    drive(4'h0);
    rd("status", STATUS_OFFSET, 32'h0000_00D0, 1'b0);
    drive(4'hF);
    rd("status", STATUS_OFFSET, 32'h0000_002F, 1'b0);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_edges();
    t_mask();
    t_ie_off();
    t_pol();
    close_out();
  end
endmodule
